/* File: logic/ssw_pkg.sv */
// constants and types shared by the status word zero register bank
package ssw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_WORD_ZERO_ADDR = 8'h11;
  localparam logic [7:0] STATUS_WORD_ZERO_RESET = 8'h80;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // field positions of status word zero
  // ----------------------------------------------------------------
  localparam int unsigned BIT_FUSE_REFRESH_BUSY = 7;
  localparam int unsigned BIT_FUSE_REFRESH_DONE = 6;
  localparam int unsigned BIT_WRITE_DURING_REFRESH_ERROR = 5;
  localparam int unsigned BIT_FIFO_DATA_AVAILABLE = 4;
  localparam int unsigned BIT_FIFO_WATERMARK = 3;
  localparam int unsigned BIT_FIFO_OVERRUN = 2;
  localparam int unsigned BIT_FIFO_FULL = 1;
  localparam int unsigned BIT_PARITY_ERROR = 0;

  // ----------------------------------------------------------------
  // fifo sizing and modes
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_LEVEL_WIDTH = 9;
  localparam logic [8:0] FIFO_EMPTY_LEVEL = 9'h000;
  localparam logic [8:0] FIFO_FULL_LEVEL = 9'h140;
  localparam logic [8:0] FIFO_FULL_LEVEL_THREE_CH = 9'h13e;
  localparam logic [2:0] THREE_CHANNELS = 3'h3;
  localparam logic [1:0] FIFO_MODE_NORMAL = 2'h0;
  localparam logic [1:0] FIFO_MODE_STREAM = 2'h1;
  localparam logic [1:0] FIFO_MODE_TRIGGER = 2'h2;

  // ----------------------------------------------------------------
  // fuse refresh timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned FUSE_REFRESH_TIME_NS = 2200000;
  // about 2.2 ms, a longest time, so the division rounds down
  localparam int unsigned FUSE_REFRESH_CYCLES = FUSE_REFRESH_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_COUNT_WIDTH = 17;

  typedef enum logic {
    SSW_REFRESHING,
    SSW_READY
  } ssw_refresh_state_e;

endpackage

/* File: logic/ssw_refresh_if.sv */
// carrier between the fuse refresh timer and the register bank
`timescale 1ns/1ps
`default_nettype none
interface ssw_refresh_if;
  logic fuse_busy_flag;
  logic refresh_finishing;

  modport timer (
    output fuse_busy_flag,
    output refresh_finishing
  );

  modport bank (
    input fuse_busy_flag,
    input refresh_finishing
  );
endinterface
`default_nettype wire

/* File: logic/ssw_sticky_bit.sv */
// one sticky status flag where a set always beats a clear
`timescale 1ns/1ps
`default_nettype none
module ssw_sticky_bit (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // flag control
  input wire logic set_in,
  input wire logic clear_in,
  // flag value
  output logic flag_out
);

  wire logic next_flag;

  // a clear only drops what was already held, a fresh set survives
  assign next_flag = set_in | (flag_out & ~clear_in);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end

endmodule
`default_nettype wire

/* File: logic/ssw_refresh_timer.sv */
// fuse refresh timer, busy from reset until the refresh time has run out
`timescale 1ns/1ps
`default_nettype none
module ssw_refresh_timer #(
  parameter int unsigned REFRESH_CYCLES = ssw_pkg::FUSE_REFRESH_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // refresh status toward the bank
  ssw_refresh_if.timer refresh
);

  localparam logic [ssw_pkg::REFRESH_COUNT_WIDTH-1:0] LAST_COUNT =
    ssw_pkg::REFRESH_COUNT_WIDTH'(REFRESH_CYCLES - 1);

  ssw_pkg::ssw_refresh_state_e state;
  logic [ssw_pkg::REFRESH_COUNT_WIDTH-1:0] count;
  wire logic at_last;

  assign at_last = (count == LAST_COUNT);
  assign refresh.fuse_busy_flag = (state == ssw_pkg::SSW_REFRESHING);
  // finishing marks the edge on which busy drops
  assign refresh.refresh_finishing = refresh.fuse_busy_flag & at_last;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= ssw_pkg::SSW_REFRESHING;
      count <= '0;
    end else begin
      case (state)
        ssw_pkg::SSW_REFRESHING: begin
          count <= count + 1'b1;
          if (at_last) begin
            state <= ssw_pkg::SSW_READY;
          end
        end
        ssw_pkg::SSW_READY: begin
          count <= '0;
        end
        default: begin
          state <= ssw_pkg::SSW_REFRESHING;
          count <= '0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: logic/ssw_status_word_zero.sv */
// status word zero register bank with clear-on-read flags
`timescale 1ns/1ps
`default_nettype none
module ssw_status_word_zero #(
  parameter int unsigned REFRESH_CYCLES = ssw_pkg::FUSE_REFRESH_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  // register access from the serial interface logic
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic reg_write_in,
  output logic [7:0] reg_read_data_out,
  // serial interface mode and chip select pin
  input wire logic spi_mode_in,
  input wire logic spi_cs_n_in,
  // fifo state and events
  input wire logic [8:0] fifo_level_in,
  input wire logic [8:0] fifo_threshold_in,
  input wire logic [2:0] channels_enabled_in,
  input wire logic [1:0] fifo_mode_in,
  input wire logic sample_written_in,
  input wire logic fifo_overflow_in,
  input wire logic fifo_read_in,
  // parity error source and trigger select
  input wire logic parity_err_in,
  input wire logic sticky_trigger_select_in,
  // status toward the rest of the device
  output logic irq_pin_zero_out,
  output logic watermark_irq_out,
  output logic write_alarm_out,
  output logic read_ptr_realign_out,
  output logic first_axis_pending_out
);

  // ----------------------------------------------------------------
  // reset
  // ----------------------------------------------------------------
  // a soft reset restarts everything here except the chip select synchroniser the same way power-on does
  wire logic bank_reset_n;

  assign bank_reset_n = reset_n_in & ~soft_reset_in;

  // ----------------------------------------------------------------
  // chip select synchroniser
  // ----------------------------------------------------------------
  // chip select comes straight off a pin, so it is resynchronised
  logic cs_n_meta;
  logic cs_n_sync;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cs_n_meta <= 1'b1;
      cs_n_sync <= 1'b1;
    end else begin
      cs_n_meta <= spi_cs_n_in;
      cs_n_sync <= cs_n_meta;
    end
  end

  // ----------------------------------------------------------------
  // fuse refresh timer
  // ----------------------------------------------------------------
  ssw_refresh_if refresh ();

  ssw_refresh_timer #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
  ) u_refresh_timer (
    .clk_in(clk_in),
    .reset_n_in(bank_reset_n),
    .refresh(refresh.timer)
  );

  wire logic fuse_refresh_busy;

  assign fuse_refresh_busy = refresh.fuse_busy_flag;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire logic status_hit;
  wire logic status_read;

  assign status_hit = (reg_addr_in == ssw_pkg::STATUS_WORD_ZERO_ADDR);
  assign status_read = reg_read_in & status_hit;

  // ----------------------------------------------------------------
  // set conditions
  // ----------------------------------------------------------------
  logic parity_err_prev;
  wire logic parity_edge;
  wire logic set_done;
  wire logic set_write_error;
  wire logic set_watermark;
  wire logic overrun_mode;
  wire logic set_overrun;
  wire logic set_parity;

  always_ff @(posedge clk_in) begin
    if (!bank_reset_n) begin
      parity_err_prev <= 1'b0;
    end else begin
      parity_err_prev <= parity_err_in;
    end
  end

  assign set_done = refresh.refresh_finishing;
  assign set_write_error = reg_write_in & fuse_refresh_busy;
  assign set_watermark = sample_written_in & (fifo_level_in >= fifo_threshold_in);
  assign overrun_mode = (fifo_mode_in == ssw_pkg::FIFO_MODE_STREAM) |
                        (fifo_mode_in == ssw_pkg::FIFO_MODE_TRIGGER);
  // normal mode leaves the overrun flag alone, its value is unspecified there
  assign set_overrun = fifo_overflow_in & overrun_mode;
  assign parity_edge = parity_err_in & ~parity_err_prev;
  assign set_parity = sticky_trigger_select_in ? parity_edge : parity_err_in;

  // ----------------------------------------------------------------
  // clear conditions
  // ----------------------------------------------------------------
  // each flag clears only if the read returned it as set
  logic flag_done;
  logic flag_write_error;
  logic flag_watermark;
  logic flag_overrun;
  logic flag_parity;
  logic watermark_clear_pending;
  wire logic clear_done;
  wire logic clear_write_error;
  wire logic clear_overrun;
  wire logic clear_parity;
  wire logic watermark_release;
  wire logic clear_watermark;
  wire logic arm_watermark_clear;

  assign clear_done = status_read & flag_done;
  assign clear_write_error = status_read & flag_write_error;
  assign clear_overrun = status_read & flag_overrun;
  assign clear_parity = status_read & flag_parity;

  // in spi mode the clear is held back until chip select goes high again
  assign watermark_release = ~spi_mode_in | cs_n_sync;
  assign arm_watermark_clear = status_read & flag_watermark;
  assign clear_watermark = (arm_watermark_clear | watermark_clear_pending) &
                           watermark_release;

  always_ff @(posedge clk_in) begin
    if (!bank_reset_n) begin
      watermark_clear_pending <= 1'b0;
    end else if (set_watermark | clear_watermark) begin
      // a new watermark event cancels a deferred clear of the old one
      watermark_clear_pending <= 1'b0;
    end else if (arm_watermark_clear) begin
      watermark_clear_pending <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  ssw_sticky_bit u_done (
    .clk_in(clk_in),
    .reset_n_in(bank_reset_n),
    .set_in(set_done),
    .clear_in(clear_done),
    .flag_out(flag_done)
  );

  ssw_sticky_bit u_write_error (
    .clk_in(clk_in),
    .reset_n_in(bank_reset_n),
    .set_in(set_write_error),
    .clear_in(clear_write_error),
    .flag_out(flag_write_error)
  );

  ssw_sticky_bit u_watermark (
    .clk_in(clk_in),
    .reset_n_in(bank_reset_n),
    .set_in(set_watermark),
    .clear_in(clear_watermark),
    .flag_out(flag_watermark)
  );

  ssw_sticky_bit u_overrun (
    .clk_in(clk_in),
    .reset_n_in(bank_reset_n),
    .set_in(set_overrun),
    .clear_in(clear_overrun),
    .flag_out(flag_overrun)
  );

  ssw_sticky_bit u_parity (
    .clk_in(clk_in),
    .reset_n_in(bank_reset_n),
    .set_in(set_parity),
    .clear_in(clear_parity),
    .flag_out(flag_parity)
  );

  // ----------------------------------------------------------------
  // live fifo flags
  // ----------------------------------------------------------------
  wire logic fifo_data_available;
  wire logic three_channel_mode;
  wire logic [8:0] full_level;
  wire logic fifo_full;

  assign fifo_data_available = (fifo_level_in != ssw_pkg::FIFO_EMPTY_LEVEL);
  assign three_channel_mode = (channels_enabled_in == ssw_pkg::THREE_CHANNELS);
  assign full_level = three_channel_mode ? ssw_pkg::FIFO_FULL_LEVEL_THREE_CH :
                                           ssw_pkg::FIFO_FULL_LEVEL;
  assign fifo_full = (fifo_level_in >= full_level);

  // ----------------------------------------------------------------
  // status word assembly and read data
  // ----------------------------------------------------------------
  logic [7:0] status_word;

  always_comb begin
    status_word = 8'h00;
    status_word[ssw_pkg::BIT_FUSE_REFRESH_BUSY] = fuse_refresh_busy;
    status_word[ssw_pkg::BIT_FUSE_REFRESH_DONE] = flag_done;
    status_word[ssw_pkg::BIT_WRITE_DURING_REFRESH_ERROR] = flag_write_error;
    status_word[ssw_pkg::BIT_FIFO_DATA_AVAILABLE] = fifo_data_available;
    status_word[ssw_pkg::BIT_FIFO_WATERMARK] = flag_watermark;
    status_word[ssw_pkg::BIT_FIFO_OVERRUN] = flag_overrun;
    status_word[ssw_pkg::BIT_FIFO_FULL] = fifo_full;
    status_word[ssw_pkg::BIT_PARITY_ERROR] = flag_parity;
  end

  wire logic [7:0] next_read_data;

  // other addresses belong to neighbouring banks and read as zero here
  assign next_read_data = status_hit ? status_word : ssw_pkg::UNMAPPED_READ_VALUE;

  always_ff @(posedge clk_in) begin
    if (!bank_reset_n) begin
      reg_read_data_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_read_data_out <= next_read_data;
    end
  end

  // ----------------------------------------------------------------
  // overrun pointer realignment
  // ----------------------------------------------------------------
  // the fifo datapath moves its read pointer on the realign pulse and
  // must hand out a first-axis word while the pending level is high
  logic next_first_axis_pending;

  always_comb begin
    next_first_axis_pending = first_axis_pending_out;
    if (set_overrun) begin
      next_first_axis_pending = 1'b1;
    end else if (fifo_read_in) begin
      next_first_axis_pending = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!bank_reset_n) begin
      read_ptr_realign_out <= 1'b0;
      first_axis_pending_out <= 1'b0;
    end else begin
      read_ptr_realign_out <= set_overrun;
      first_axis_pending_out <= next_first_axis_pending;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // these follow the flags directly; pin mapping and polarity live elsewhere
  assign irq_pin_zero_out = fuse_refresh_busy;
  assign watermark_irq_out = flag_watermark;
  assign write_alarm_out = flag_write_error;

endmodule
`default_nettype wire

/* File: testbench/ssw_status_props.sv */
// concurrent checks on the status word zero bank ports
`timescale 1ns/1ps
`default_nettype none
module ssw_status_props #(
  parameter int unsigned REFRESH_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  // watched inputs
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic reg_write_in,
  input wire logic spi_mode_in,
  input wire logic spi_cs_n_in,
  input wire logic [8:0] fifo_level_in,
  input wire logic [8:0] fifo_threshold_in,
  input wire logic [2:0] channels_enabled_in,
  input wire logic [1:0] fifo_mode_in,
  input wire logic sample_written_in,
  input wire logic fifo_overflow_in,
  input wire logic fifo_read_in,
  input wire logic parity_err_in,
  input wire logic sticky_trigger_select_in,
  // watched outputs
  input wire logic [7:0] reg_read_data_out,
  input wire logic irq_pin_zero_out,
  input wire logic watermark_irq_out,
  input wire logic write_alarm_out,
  input wire logic first_axis_pending_out
);
  logic rst;
  logic rd0;
  int unsigned cnt;
  assign rst = !reset_n_in || soft_reset_in;
  assign rd0 = reg_read_in && (reg_addr_in == ssw_pkg::STATUS_WORD_ZERO_ADDR);
  // saturates so a long run cannot wrap back into the busy window
  always_ff @(posedge clk_in) begin
    if (rst) cnt <= 0;
    else if (cnt < REFRESH_CYCLES) cnt <= cnt + 1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst);
  sequence s_cs_low;
    spi_mode_in && !spi_cs_n_in;
  endsequence
  sequence s_overrun;
    fifo_overflow_in && (fifo_mode_in == 2'h1 || fifo_mode_in == 2'h2);
  endsequence
  sequence s_parity_live;
    parity_err_in && !sticky_trigger_select_in;
  endsequence
  a_busy_span: assert property (irq_pin_zero_out == (cnt < REFRESH_CYCLES))
    else $error("busy flag span wrong");
  a_busy_readback: assert property (rd0 |=> reg_read_data_out[7] == $past(irq_pin_zero_out))
    else $error("busy bit differs from pin");
  a_unmapped_zero: assert property (reg_read_in && !rd0 |=> reg_read_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_full_level: assert property (rd0 |=> reg_read_data_out[1] == ($past(fifo_level_in) >=
    ($past(channels_enabled_in) == 3'h3 ? 9'h13e : 9'h140))) else $error("full bit wrong");
  a_write_alarm: assert property (reg_write_in && irq_pin_zero_out |=> write_alarm_out)
    else $error("write during refresh missed");
  a_wm_set: assert property (sample_written_in && fifo_level_in >= fifo_threshold_in
    |=> watermark_irq_out) else $error("watermark not set");
  a_wm_i2c_clear: assert property (rd0 && !spi_mode_in && !sample_written_in
    && watermark_irq_out |=> !watermark_irq_out) else $error("watermark not cleared");
  a_wm_cs_hold: assert property (s_cs_low [*4] ##0 watermark_irq_out |=> watermark_irq_out)
    else $error("watermark cleared with select low");
  a_overrun_mark: assert property (s_overrun |=> first_axis_pending_out)
    else $error("overrun not marked");
  a_first_axis: assert property (first_axis_pending_out && fifo_read_in && !fifo_overflow_in
    |=> !first_axis_pending_out) else $error("first axis mark stuck");
  a_parity_live: assert property (s_parity_live ##1 (s_parity_live and rd0)
    |=> reg_read_data_out[0]) else $error("live parity lost");
endmodule
`default_nettype wire

/* File: testbench/ssw_host_model.sv */
// host model issuing single register accesses and driving chip select
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model (
  // clock and read data
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  // register strobes and select pin
  output logic [7:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic cs_n_out
);
  initial begin
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic access(input logic [7:0] a, input logic wr, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = !wr;
    wr_out = wr;
    @(posedge clk_in);
    #1;
    d = rd_data_in;
    rd_out = 1'b0;
    wr_out = 1'b0;
    // stale address must not look like a held one
    addr_out = ~a;
  endtask
  task automatic select(input logic on);
    @(posedge clk_in);
    #1;
    cs_n_out = !on;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the status word zero register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned RC = 16;
  localparam int unsigned WATCHDOG_NS = 40 * 2000;
  localparam logic [7:0] A0 = ssw_pkg::STATUS_WORD_ZERO_ADDR;
  logic clk_in, reset_n_in, soft_reset_in, reg_read_in, reg_write_in, spi_mode_in, spi_cs_n_in;
  logic sample_written_in, fifo_overflow_in, fifo_read_in, parity_err_in, sticky_trigger_select_in;
  logic irq_pin_zero_out, watermark_irq_out, write_alarm_out, read_ptr_realign_out;
  logic first_axis_pending_out;
  logic [7:0] reg_addr_in, reg_read_data_out;
  logic [8:0] fifo_level_in, fifo_threshold_in;
  logic [2:0] channels_enabled_in;
  logic [1:0] fifo_mode_in;
  int n_fail, total_checks;
  ssw_status_word_zero #(.REFRESH_CYCLES(RC)) dut (.clk_in, .reset_n_in, .soft_reset_in,
    .reg_addr_in, .reg_read_in, .reg_write_in, .reg_read_data_out, .spi_mode_in, .spi_cs_n_in,
    .fifo_level_in, .fifo_threshold_in, .channels_enabled_in, .fifo_mode_in, .sample_written_in,
    .fifo_overflow_in, .fifo_read_in, .parity_err_in, .sticky_trigger_select_in,
    .irq_pin_zero_out, .watermark_irq_out, .write_alarm_out, .read_ptr_realign_out,
    .first_axis_pending_out);
  ssw_host_model host (.clk_in, .rd_data_in(reg_read_data_out), .addr_out(reg_addr_in),
    .rd_out(reg_read_in), .wr_out(reg_write_in), .cs_n_out(spi_cs_n_in));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic rd0(input logic [7:0] exp);
    logic [7:0] d;
    logic [7:0] m;
    // overrun bit has no meaning in normal fifo mode, so it is masked there
    m = (fifo_mode_in == ssw_pkg::FIFO_MODE_NORMAL) ? 8'hfb : 8'hff;
    host.access(A0, 1'b0, d);
    chk(d & m, exp & m);
  endtask
  task automatic t_refresh(input logic use_soft);
    int n;
    logic [7:0] d;
    tick(1);
    if (use_soft) soft_reset_in = 1'b1;
    else reset_n_in = 1'b0;
    tick(6);
    reset_n_in = 1'b1;
    soft_reset_in = 1'b0;
    chk({7'h00, irq_pin_zero_out}, 8'h01);
    rd0(8'h80);
    host.access(A0, 1'b1, d);
    chk({7'h00, write_alarm_out}, 8'h01);
    rd0(8'ha0);
    rd0(8'h80);
    n = 0;
    while (irq_pin_zero_out === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    rd0(8'h40);
    rd0(8'h00);
  endtask
  task automatic t_unmapped();
    logic [7:0] d;
    host.access(8'h12, 1'b0, d);
    chk(d, 8'h00);
    host.access(A0, 1'b1, d);
    chk({7'h00, write_alarm_out}, 8'h00);
  endtask
  task automatic t_fifo();
    logic [8:0] lv [5] = '{9'h001, 9'h140, 9'h13e, 9'h13e, 9'h13f};
    logic [2:0] cn [5] = '{3'h1, 3'h1, 3'h3, 3'h2, 3'h1};
    logic [7:0] ex [5] = '{8'h10, 8'h12, 8'h12, 8'h10, 8'h10};
    for (int i = 0; i < 5; i++) begin
      fifo_level_in = lv[i];
      channels_enabled_in = cn[i];
      rd0(ex[i]);
    end
    fifo_level_in = 9'h000;
  endtask
  task automatic t_wm(input logic spi);
    spi_mode_in = spi;
    fifo_threshold_in = 9'h005;
    for (int i = 4; i < 6; i++) begin
      fifo_level_in = i[8:0];
      sample_written_in = 1'b1;
      tick(1);
      sample_written_in = 1'b0;
      chk({7'h00, watermark_irq_out}, {7'h00, i == 5});
    end
    // select must pass the two-flop synchroniser before the read is taken
    if (spi) begin
      host.select(1'b1);
      tick(2);
    end
    rd0(8'h18);
    chk({7'h00, watermark_irq_out}, {7'h00, spi});
    if (spi) begin
      tick(3);
      chk({7'h00, watermark_irq_out}, 8'h01);
      host.select(1'b0);
      tick(4);
      chk({7'h00, watermark_irq_out}, 8'h00);
    end
    fifo_level_in = 9'h000;
    spi_mode_in = 1'b0;
  endtask
  task automatic t_overrun();
    for (logic [1:0] m = 2'h1; m != 2'h3; m++) begin
      fifo_mode_in = m;
      fifo_overflow_in = 1'b1;
      tick(1);
      fifo_overflow_in = 1'b0;
      chk({6'h00, read_ptr_realign_out, first_axis_pending_out}, 8'h03);
      tick(1);
      chk({6'h00, read_ptr_realign_out, first_axis_pending_out}, 8'h01);
      rd0(8'h04);
      fifo_read_in = 1'b1;
      tick(1);
      fifo_read_in = 1'b0;
      chk({7'h00, first_axis_pending_out}, 8'h00);
    end
    fifo_mode_in = ssw_pkg::FIFO_MODE_NORMAL;
  endtask
  task automatic t_parity();
    parity_err_in = 1'b1;
    tick(2);
    rd0(8'h01);
    rd0(8'h01);
    parity_err_in = 1'b0;
    rd0(8'h01);
    rd0(8'h00);
    sticky_trigger_select_in = 1'b1;
    parity_err_in = 1'b1;
    tick(1);
    rd0(8'h01);
    rd0(8'h00);
    parity_err_in = 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    {reset_n_in, soft_reset_in, spi_mode_in, sample_written_in, fifo_overflow_in} = 5'h00;
    {fifo_read_in, parity_err_in, sticky_trigger_select_in} = 3'h0;
    fifo_level_in = 9'h000;
    fifo_threshold_in = 9'h005;
    channels_enabled_in = 3'h1;
    fifo_mode_in = ssw_pkg::FIFO_MODE_NORMAL;
    n_fail = 0;
    total_checks = 0;
    t_refresh(1'b0);
    t_unmapped();
    t_fifo();
    t_wm(1'b0);
    t_wm(1'b1);
    t_overrun();
    t_parity();
    t_refresh(1'b1);
    summarize();
  end
  initial begin
    #(WATCHDOG_NS);
    n_fail++;
    summarize();
  end
endmodule
bind ssw_status_word_zero ssw_status_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) props (.clk_in,
  .reset_n_in, .soft_reset_in, .reg_addr_in, .reg_read_in, .reg_write_in, .spi_mode_in,
  .spi_cs_n_in, .fifo_level_in, .fifo_threshold_in, .channels_enabled_in, .fifo_mode_in,
  .sample_written_in, .fifo_overflow_in, .fifo_read_in, .parity_err_in,
  .sticky_trigger_select_in, .reg_read_data_out, .irq_pin_zero_out, .watermark_irq_out,
  .write_alarm_out, .first_axis_pending_out);
`default_nettype wire
